// ===== rtl/pin_mode_map.svh
// Purpose: Offsets, field positions, reset values and counts for the pin mode block
// Assumes: Included by bare name from the package and the control block design file
// Notes: Definitions only
`ifndef PIN_MODE_MAP_SVH
`define PIN_MODE_MAP_SVH

// ==========================================================
// Widths and counts
`define SAMPLE_BITS 12
`define DDR_PAIRS 6
`define FIFO_WORDS 16
`define REG_WORDS 4
`define REG_BITS 8

// ==========================================================
// Serial frame layout
`define FRAME_LAST_ADDR_BIT 5'd7
`define FRAME_LAST_BIT 5'd15

// ==========================================================
// Internal register map
`define CTRL_REG_ADDR 8'h00
`define CTRL_READOUT_BIT 0
`define CTRL_SWRESET_BIT 1
`define REG_RESET_VALUE 8'h00

`endif

// ===== rtl/pin_mode_pkg.sv
// Purpose: Types shared by the pin mode block
// Assumes: pin_mode_map.svh holds the numbers
// Notes: Types only
`include "pin_mode_map.svh"

package pin_mode_pkg;

  // ==========================================================
  // Sample from the converter core
  typedef struct packed {
    logic overrange;                  // Input out of range
    logic [`SAMPLE_BITS-1:0] data;    // Offset binary code
  } sample_t;

  // Decoded format select level
  typedef struct packed {
    logic ddr;    // 1: differential double rate, 0: parallel single ended
    logic twos;   // 1: two's complement, 0: offset binary
  } fmt_t;

  // Serial port states
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_ADDR,
    SER_DATA
  } ser_state_t;

endpackage

// ===== rtl/sample_fifo.sv
// Purpose: Sample buffer between converter core and output stage
// Assumes: One clock; valid/ready on both sides
// Notes: Read data come out of a register
`timescale 1ns/100ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [AW-1:0] wr_ptr;           // Write index
  logic [AW-1:0] rd_ptr;           // Read index
  logic [AW:0] count;              // Words in storage
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic next_in_ready;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push;
  logic load;

  // ==========================================================
  // Next state
  // Output register refills whenever empty or being taken
  always_comb begin
    push = in_valid_i & in_ready_o;
    load = (count != '0) & (~out_valid_o | out_ready_i);
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = load ? rd_ptr + AW'(1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(load);
    next_out_data = load ? mem[rd_ptr] : out_data_o;
    if (load) begin
      next_out_valid = 1'b1;
    end else if (out_ready_i) begin
      next_out_valid = 1'b0;
    end else begin
      next_out_valid = out_valid_o;
    end
    // Registered full flag taken from next_count, so ready drops and returns on the same edge as the count
    next_in_ready = next_count != (AW+1)'(DEPTH);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready_o <= next_in_ready;
      out_valid_o <= next_out_valid;
      out_data_o <= next_out_data;
    end
  end

  // Storage holds data only, so no reset
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/control_pin_mode_select.sv
// Purpose: Control pin mode selection, serial port, readback pin and sample output stage
// Assumes: Pins are asynchronous and pass two flip-flops; samples arrive on core_clk_i
// Notes: Serial enable is active low; output clock runs at half of core_clk_i, rising with each word
//
// Function
// (RULE_01) Output buffers enabled only while enable high
// (RULE_02) Readback bit zero: pin shows overrange
// (RULE_03) Readback bit one: pin shifts register out
// (RULE_04) Host initialises registers before serial use
// (RULE_05) Hardware reset high holds registers default
// (RULE_06) Reset high: serial enable is static control
// (RULE_07) Reset low: serial clock clocks port
// (RULE_08) Reset high: host grounds serial clock
// (RULE_09) Reset low: serial data feeds port
// (RULE_10) Reset high: serial data is standby
// (RULE_11) Reset low: serial enable frames transfers
// (RULE_12) Unused serial enable held at supply
// (RULE_13) Parallel mode: twelve bits plus clock
// (RULE_14) Double rate: two bits per pair
// (RULE_15) Format select picks coding and interface
// (RULE_16) Disabled buffers float, no data driven
`timescale 1ns/100ps
`default_nettype none
`include "pin_mode_map.svh"

module control_pin_mode_select (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_pin_i,
  input wire logic serial_clk_pin_i,
  input wire logic serial_data_in_i,
  input wire logic serial_enable_pin_i,
  input wire logic output_enable_pin_i,
  input wire logic [1:0] format_select_pin_i,
  input wire pin_mode_pkg::sample_t sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  output logic [`SAMPLE_BITS-1:0] parallel_out_bits_o,
  output logic parallel_out_oe_o,
  output logic sample_clock_out_o,
  output logic sample_clock_oe_o,
  output logic [`DDR_PAIRS-1:0] ddr_pair_p_o,
  output logic [`DDR_PAIRS-1:0] ddr_pair_n_o,
  output logic ddr_oe_o,
  output logic overrange_or_readback_pin_o,
  output logic standby_o,
  output logic static_control_o
);
  import pin_mode_pkg::*;

  // ==========================================================
  // Pin synchronisers
  localparam int PINS = 7;
  // Reset levels match the idle pins, so no false frame follows reset
  localparam logic [PINS-1:0] PIN_IDLE = 7'h08;
  logic [PINS-1:0] pin_raw;     // Raw pin levels
  logic [PINS-1:0] pin_meta;    // First stage, read only by second
  logic [PINS-1:0] pin_sync;    // Second stage, safe to use
  logic sclk_prev;              // Serial clock one sample back
  logic hw_high;                // Hardware reset pin high
  logic sclk_s;
  logic data_pin_s;
  logic enable_pin_s;
  logic oe_s;
  fmt_t fmt;

  assign pin_raw = {format_select_pin_i, output_enable_pin_i, serial_enable_pin_i,
                    serial_data_in_i, serial_clk_pin_i, hw_reset_pin_i};

  // Two flops per pin
  generate
    for (genvar i = 0; i < PINS; i++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          pin_meta[i] <= PIN_IDLE[i];
          pin_sync[i] <= PIN_IDLE[i];
        end else begin
          pin_meta[i] <= pin_raw[i];
          pin_sync[i] <= pin_meta[i];
        end
      end
    end
  endgenerate

  assign hw_high = pin_sync[0];
  assign sclk_s = pin_sync[1];
  assign data_pin_s = pin_sync[2];
  assign enable_pin_s = pin_sync[3];
  assign oe_s = pin_sync[4];
  assign fmt = fmt_t'(pin_sync[6:5]);   // [RULE_15]

  // Register index when the address hits the bank
  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    reg_index = addr[1:0];
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = addr < 8'(`REG_WORDS);
  endfunction

  // ==========================================================
  // Serial port and register bank
  ser_state_t ser_state;
  ser_state_t next_ser_state;
  logic [4:0] bit_cnt;                          // Bits taken in this frame
  logic [4:0] next_bit_cnt;
  logic [15:0] shift;                           // Address then data
  logic [15:0] next_shift;
  logic [7:0] rd_shift;                         // Readback data
  logic [7:0] next_rd_shift;
  logic [`REG_BITS-1:0] regs [`REG_WORDS];      // Internal registers
  logic [`REG_BITS-1:0] next_regs [`REG_WORDS];
  logic sclk_rise;
  logic sclk_fall;
  logic frame;
  logic readout;
  logic [7:0] cur_addr;
  logic [7:0] wr_data;

  always_comb begin
    sclk_rise = sclk_s & ~sclk_prev;
    sclk_fall = ~sclk_s & sclk_prev;
    frame = ~hw_high & ~enable_pin_s;           // [RULE_11]
    readout = regs[0][`CTRL_READOUT_BIT];
    cur_addr = {shift[6:0], data_pin_s};
    wr_data = {shift[6:0], data_pin_s};
    next_ser_state = ser_state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_rd_shift = rd_shift;
    next_regs = regs;
    if (!frame) begin
      // Frame ends on enable; clock edges outside a frame are ignored
      next_ser_state = SER_IDLE;
      next_bit_cnt = 5'd0;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          next_ser_state = SER_ADDR;
        end
        SER_ADDR: begin
          if (sclk_rise) begin                   // [RULE_07]
            next_shift = {shift[14:0], data_pin_s}; // [RULE_09]
            next_bit_cnt = bit_cnt + 5'd1;
            if (bit_cnt == `FRAME_LAST_ADDR_BIT) begin
              next_ser_state = SER_DATA;
              next_rd_shift = reg_hit(cur_addr) ? regs[reg_index(cur_addr)] : 8'h00;
            end
          end
        end
        SER_DATA: begin
          if (sclk_fall) begin
            next_rd_shift = {rd_shift[6:0], 1'b0};
          end
          if (sclk_rise) begin
            next_shift = {shift[14:0], data_pin_s};
            next_bit_cnt = bit_cnt + 5'd1;
            if (bit_cnt == `FRAME_LAST_BIT) begin
              next_ser_state = SER_IDLE;
              // In readback only the control word may be written
              if (reg_hit(shift[14:7]) && (!readout || shift[14:7] == `CTRL_REG_ADDR)) begin
                next_regs[reg_index(shift[14:7])] = wr_data;
              end
            end
          end
        end
        default: begin
          next_ser_state = SER_IDLE;
        end
      endcase
    end
    // Software reset bit clears the bank and is not kept
    if (next_regs[0][`CTRL_SWRESET_BIT]) begin
      for (int k = 0; k < `REG_WORDS; k++) begin
        next_regs[k] = `REG_RESET_VALUE;
      end
    end
  end

  // Serial and bank registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || hw_high) begin                 // [RULE_05]
      ser_state <= SER_IDLE;
      bit_cnt <= 5'd0;
      shift <= 16'h0000;
      rd_shift <= 8'h00;
      sclk_prev <= 1'b0;
      for (int k = 0; k < `REG_WORDS; k++) begin
        regs[k] <= `REG_RESET_VALUE;
      end
    end else begin
      ser_state <= next_ser_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      rd_shift <= next_rd_shift;
      sclk_prev <= sclk_s;
      regs <= next_regs;
    end
  end

  // ==========================================================
  // Output stage
  // Two core cycles per word: phase 0 low half, phase 1 high half
  logic [`SAMPLE_BITS-1:0] fifo_data;
  logic fifo_ovr;
  logic fifo_valid;
  logic fifo_ready;
  logic phase;
  logic next_phase;
  logic [`SAMPLE_BITS-1:0] word;       // Coded word on the pins
  logic [`SAMPLE_BITS-1:0] next_word;
  logic word_ovr;
  logic next_word_ovr;
  logic run;
  logic [`SAMPLE_BITS-1:0] next_par;
  logic [`DDR_PAIRS-1:0] next_pair;
  logic next_clk;
  logic next_ovr_pin;
  logic next_standby;
  logic next_static;

  sample_fifo #(
    .WIDTH(`SAMPLE_BITS + 1),
    .DEPTH(`FIFO_WORDS)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o({fifo_ovr, fifo_data}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );

  always_comb begin
    next_standby = hw_high & data_pin_s;            // [RULE_10]
    next_static = hw_high & enable_pin_s;           // [RULE_06]
    // Standby or disabled buffers stall the drain, so the buffer fills
    run = oe_s & ~next_standby;
    fifo_ready = run & ~phase;
    next_phase = run ? ~phase : 1'b0;
    next_word = word;
    next_word_ovr = word_ovr;
    if (fifo_ready && fifo_valid) begin
      // Core gives offset binary; flip the sign bit for two's complement
      next_word = fifo_data ^ {fmt.twos, {(`SAMPLE_BITS-1){1'b0}}}; // [RULE_15]
      next_word_ovr = fifo_ovr;
    end
    next_clk = run & next_phase;
    for (int p = 0; p < `DDR_PAIRS; p++) begin
      next_pair[p] = next_phase ? next_word[2*p+1] : next_word[2*p]; // [RULE_14]
    end
    // Undriven pins also carry zero so no stale sample shows
    next_par = (oe_s && !fmt.ddr) ? next_word : '0;                   // [RULE_13] [RULE_16]
    if (!oe_s || !fmt.ddr) begin
      next_pair = '0;                                                 // [RULE_16]
    end
    next_ovr_pin = readout ? (rd_shift[7] & (ser_state == SER_DATA)) // [RULE_03]
                           : next_word_ovr;                          // [RULE_02]
  end

  // Output registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase <= 1'b0;
      word <= '0;
      word_ovr <= 1'b0;
      parallel_out_bits_o <= '0;
      parallel_out_oe_o <= 1'b0;
      sample_clock_out_o <= 1'b0;
      sample_clock_oe_o <= 1'b0;
      ddr_pair_p_o <= '0;
      ddr_pair_n_o <= '0;
      ddr_oe_o <= 1'b0;
      overrange_or_readback_pin_o <= 1'b0;
      standby_o <= 1'b0;
      static_control_o <= 1'b0;
    end else begin
      phase <= next_phase;
      word <= next_word;
      word_ovr <= next_word_ovr;
      parallel_out_bits_o <= next_par;
      parallel_out_oe_o <= oe_s & ~fmt.ddr;        // [RULE_01]
      sample_clock_out_o <= oe_s & next_clk;
      sample_clock_oe_o <= oe_s;                   // [RULE_01] [RULE_16]
      ddr_pair_p_o <= next_pair;
      ddr_pair_n_o <= (oe_s && fmt.ddr) ? ~next_pair : '0;
      ddr_oe_o <= oe_s & fmt.ddr;                  // [RULE_01]
      overrange_or_readback_pin_o <= next_ovr_pin;
      standby_o <= next_standby;
      static_control_o <= next_static;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/pin_mode_asserts.sv
// Purpose: Concurrent checks on the pin mode block outputs
// Assumes: Pins pass two sync flops plus one output register
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none

module pin_mode_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_pin_i,
  input wire logic serial_data_in_i,
  input wire logic serial_enable_pin_i,
  input wire logic output_enable_pin_i,
  input wire logic [1:0] format_select_pin_i,
  input wire logic [11:0] parallel_out_bits_o,
  input wire logic parallel_out_oe_o,
  input wire logic sample_clock_oe_o,
  input wire logic [5:0] ddr_pair_p_o,
  input wire logic [5:0] ddr_pair_n_o,
  input wire logic ddr_oe_o,
  input wire logic standby_o,
  input wire logic static_control_o
);
  // ==========================================================
  // Timing frame
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Four edges cover the three edge sync and register delay
  sequence s_oe_off; !output_enable_pin_i [*4]; endsequence
  sequence s_par_on; (output_enable_pin_i && !format_select_pin_i[1]) [*4]; endsequence
  sequence s_hw_serial_data_in; (hw_reset_pin_i && serial_data_in_i) [*4]; endsequence
  sequence s_hw_enable; (hw_reset_pin_i && serial_enable_pin_i) [*4]; endsequence
  sequence s_hw_low; !hw_reset_pin_i [*4]; endsequence

  // ==========================================================
  // Assertions
  a_oe_off: assert property (s_oe_off |-> !parallel_out_oe_o && !ddr_oe_o && !sample_clock_oe_o)
    else $error("outputs enabled while enable pin low");
  a_par_on: assert property (s_par_on |-> parallel_out_oe_o && !ddr_oe_o && sample_clock_oe_o)
    else $error("parallel outputs not enabled");
  a_oe_excl: assert property (!(parallel_out_oe_o && ddr_oe_o))
    else $error("both interfaces enabled");
  a_bits_float: assert property (!parallel_out_oe_o |-> parallel_out_bits_o == 12'h000)
    else $error("parallel bits driven while disabled");
  a_ddr_float: assert property (!ddr_oe_o |-> (ddr_pair_p_o | ddr_pair_n_o) == 6'h00)
    else $error("pairs driven while disabled");
  a_ddr_compl: assert property (ddr_oe_o |-> ddr_pair_n_o == ~ddr_pair_p_o)
    else $error("pair legs not complementary");
  a_standby_on: assert property (s_hw_serial_data_in |-> standby_o)
    else $error("standby not taken from data pin");
  a_static_on: assert property (s_hw_enable |-> static_control_o)
    else $error("static control not taken from enable pin");
  a_serial_quiet: assert property (s_hw_low |-> !standby_o && !static_control_o)
    else $error("static controls active in serial mode");
endmodule

bind control_pin_mode_select pin_mode_asserts chk (.core_clk_i, .rst_n_i, .hw_reset_pin_i,
  .serial_data_in_i, .serial_enable_pin_i, .output_enable_pin_i, .format_select_pin_i,
  .parallel_out_bits_o, .parallel_out_oe_o, .sample_clock_oe_o, .ddr_pair_p_o,
  .ddr_pair_n_o, .ddr_oe_o, .standby_o, .static_control_o);

`default_nettype wire

// ===== testbench/host_pins_model.sv
// Purpose: Host driving the configuration pins
// Assumes: Serial clock 320 ns, idle low; enable active low
// Notes: Data pin rests at its pull-down level outside frames
`timescale 1ns/100ps
`default_nettype none

module host_pins_model (
  output logic hw_reset_pin_o,
  output logic serial_clk_pin_o,
  output logic serial_data_out_o,
  output logic serial_enable_pin_o,
  input wire logic readback_pin_i
);
  // ==========================================================
  // Idle levels
  initial begin
    hw_reset_pin_o = 1'b0;
    serial_clk_pin_o = 1'b0;
    serial_data_out_o = 1'b0;
    serial_enable_pin_o = 1'b1;
  end

  // Static levels for the hardware reset mode
  task automatic set_pins(input logic h, input logic d, input logic e);
    hw_reset_pin_o = h;
    serial_data_out_o = d;
    serial_enable_pin_o = e;
  endtask

  // Registers must start from defaults before serial use
  task automatic init_pulse();
    set_pins(1'b1, 1'b0, 1'b1);
    #400;
    set_pins(1'b0, 1'b0, 1'b1);
    #400;
  endtask

  // One frame, MSB first; readback sampled late in the high halves of bits 8 down to 1
  task automatic frame(input logic [15:0] word, output logic [7:0] rb);
    int i;
    rb = 8'h00;
    #13;
    serial_enable_pin_o = 1'b0;
    for (i = 15; i >= 0; i--) begin
      serial_data_out_o = word[i];
      #160;
      serial_clk_pin_o = 1'b1;
      #160;
      if (i <= 8 && i >= 1) begin
        rb = {rb[6:0], readback_pin_i};
      end
      serial_clk_pin_o = 1'b0;
    end
    #160;
    serial_enable_pin_o = 1'b1;
    serial_data_out_o = 1'b0;
    #320;
  endtask
endmodule

`default_nettype wire

// ===== testbench/control_pin_mode_select_bench.sv
// Purpose: Self-checking bench for the pin mode block
// Assumes: Inputs change at the falling clock edge
// Notes: Host pins come from the partner model
`timescale 1ns/100ps
`default_nettype none

module control_pin_mode_select_bench;
  import pin_mode_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic oe = 1'b1;
  logic [1:0] fmt = 2'b00;
  sample_t smp = '0;
  logic vld = 1'b0;
  logic hw, sclk, sdi, frame_n;
  logic ready, bits_oe, ck, ck_oe, ddr_oe, pin, stby, stat;
  logic [11:0] bits;
  logic [5:0] dp, dn;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #20 core_clk_i = ~core_clk_i;

  control_pin_mode_select uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hw_reset_pin_i(hw),
    .serial_clk_pin_i(sclk), .serial_data_in_i(sdi), .serial_enable_pin_i(frame_n),
    .output_enable_pin_i(oe), .format_select_pin_i(fmt), .sample_i(smp), .sample_valid_i(vld),
    .sample_ready_o(ready), .parallel_out_bits_o(bits), .parallel_out_oe_o(bits_oe),
    .sample_clock_out_o(ck), .sample_clock_oe_o(ck_oe), .ddr_pair_p_o(dp), .ddr_pair_n_o(dn),
    .ddr_oe_o(ddr_oe), .overrange_or_readback_pin_o(pin), .standby_o(stby), .static_control_o(stat));

  host_pins_model host (.hw_reset_pin_o(hw), .serial_clk_pin_o(sclk), .serial_data_out_o(sdi),
    .serial_enable_pin_o(frame_n), .readback_pin_i(pin));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Offer one word; ready seen at the negedge holds for the next edge
  task automatic push(input logic ovr, input logic [11:0] d, output logic took);
    smp = {ovr, d};
    vld = 1'b1;
    took = ready;
    @(negedge core_clk_i);
  endtask

  // Clock runs free, so skip the two cycles an old word may still show
  // Word and clock rise together: odd bits in the high half, even bits after
  task automatic get_word(output logic [11:0] w, output logic [5:0] ev, output logic [5:0] od,
                          output logic ov, output logic hi);
    int n;
    repeat (2) @(negedge core_clk_i);
    for (n = 0; n < 30 && ck !== 1'b1; n++) begin
      @(negedge core_clk_i);
    end
    hi = ck;
    w = bits;
    od = dp;
    ov = pin;
    @(negedge core_clk_i);
    ev = dp;
  endtask

  // ==========================================================
  // Scenarios
  // Every format code, with overrange set on the odd ones
  task automatic t_formats();
    logic t, v, k;
    logic [11:0] w, c;
    logic [5:0] e, o, xe, xo;
    int f, p;
    for (f = 0; f < 4; f++) begin
      fmt = f[1:0];
      repeat (4) @(negedge core_clk_i);
      c = 12'h6b5 ^ {f[0], 11'h000};
      for (p = 0; p < 6; p++) begin
        xe[p] = c[2*p];
        xo[p] = c[2*p+1];
      end
      push(f[0], 12'h6b5, t);
      vld = 1'b0;
      get_word(w, e, o, v, k);
      chk(k, 1'b1, "output clock");
      chk({ddr_oe, bits_oe}, {f[1], ~f[1]}, "interface select");
      chk(v, f[0], "overrange flag");
      if (f[1]) begin
        chk({e, o}, {xe, xo}, "pair bits");
      end else begin
        chk(w, c, "parallel word");
      end
    end
  endtask

  // Disabled outputs stall the path until the buffer refuses
  task automatic t_fill();
    logic t, v, k;
    logic [11:0] w;
    logic [5:0] e, o;
    int i, n;
    fmt = 2'b00;
    oe = 1'b0;
    repeat (4) @(negedge core_clk_i);
    chk({bits_oe, ddr_oe, ck_oe, bits}, 16'h0000, "disabled outputs");
    n = 0;
    for (i = 0; i < 20; i++) begin
      push(1'b0, i[11:0], t);
      n += t;
    end
    vld = 1'b0;
    chk(n[15:0], 16'd17, "words held");
    oe = 1'b1;
    get_word(w, e, o, v, k);
    chk(k, 1'b1, "clock after enable");
    chk(w, 12'h000, "first drained word");
    repeat (45) @(negedge core_clk_i);
    chk(ready, 1'b1, "buffer drained");
  endtask

  // Serial writes, readback, unmapped read and hardware reset defaults
  task automatic t_serial();
    logic [7:0] r;
    host.init_pulse();
    host.frame(16'h025a, r);
    host.frame(16'h0001, r);
    host.frame(16'h0200, r);
    chk(r, 8'h5a, "readback");
    host.frame(16'h0700, r);
    chk(r, 8'h00, "unmapped read");
    host.frame(16'h0002, r);
    host.frame(16'h0001, r);
    host.frame(16'h0200, r);
    chk(r, 8'h00, "register after software reset");
    host.frame(16'h0000, r);
    host.frame(16'h025a, r);
    host.init_pulse();
    host.frame(16'h0001, r);
    host.frame(16'h0200, r);
    chk(r, 8'h00, "register after reset");
    host.frame(16'h0000, r);
  endtask

  // Hardware reset held: data and enable pins act as static controls
  task automatic t_hw_high();
    host.set_pins(1'b1, 1'b1, 1'b1);
    repeat (5) @(negedge core_clk_i);
    chk({stby, stat}, 2'b11, "static controls set");
    host.set_pins(1'b1, 1'b0, 1'b0);
    repeat (5) @(negedge core_clk_i);
    chk({stby, stat}, 2'b00, "static controls clear");
    host.set_pins(1'b0, 1'b0, 1'b1);
    repeat (5) @(negedge core_clk_i);
  endtask

  // ==========================================================
  // Closing report and run control
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly two thousand cycles needed
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    t_formats();
    t_fill();
    t_serial();
    t_hw_high();
    print_verdict();
  end
endmodule

`default_nettype wire
